// ==== rtl/tws_top.sv ====
// Purpose: two-wire slave receiver with register file on APB and queued START
// Assumes: APB master per AMBA; scl/sda pins are open drain, inputs synchronous
// Notes: received events pass a small buffer; the engine stretches scl while an event waits on a full buffer
`timescale 1ns/10ps
module tws_top #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned BUF_DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic job_done,
  output logic interrupt_on
);
  // refuse parameters the decode and buffer cannot serve
  if (ADDR_W < 10 || BUF_DEPTH < 2) begin : g_bad_cfg
    $error("tws_top: ADDR_W must reach index 0xBD and BUF_DEPTH be at least 2");
  end

  // register state
  logic [7:0] divider_q;
  logic [1:0] prescale_q;
  logic [4:0] code_q;
  logic [6:0] own_addr_q;
  logic gce_q;
  logic [7:0] data_q;
  logic done_q;
  logic ack_en_q;
  logic begin_q;
  logic halt_q;
  logic wcol_q;
  logic on_q;
  logic irq_en_q;
  logic [6:0] mask_q;
  logic [31:0] prdata_q;

  // engine state
  tws_pkg::tws_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic addressed_q;
  logic gc_q;
  logic ack_q;
  logic [4:0] pend_code_q;
  logic ev_valid_q;
  logic [tws_pkg::EV_W-1:0] ev_data_q;
  logic [15:0] hold_cnt_q;
  logic sda_oe_q;
  logic scl_oe_q;
  logic halt_done;

  // line monitor and buffer wiring
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic bus_busy;
  logic sda_now;
  logic ev_ready;
  logic buf_valid;
  logic [tws_pkg::EV_W-1:0] buf_data;
  logic pop;

  // bus decode
  logic [7:0] idx;
  logic wr_en;
  logic rd_setup;
  logic release_pulse;

  // an index is mapped only inside the two-wire window
  function automatic logic reg_hit(input logic [7:0] i);
    reg_hit = (i >= tws_pkg::IDX_DIVIDER) && (i <= tws_pkg::IDX_MASK);
  endfunction

  assign idx = paddr[9:2];
  assign wr_en = psel && penable && pwrite && reg_hit(idx);
  assign rd_setup = psel && !penable && !pwrite;
  // zero wait states: read data was captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(idx);
  assign prdata = prdata_q;
  // R13 software release: writing done as 1 hands control back to the engine
  assign release_pulse = wr_en && (idx == tws_pkg::IDX_CTRL) && pwdata[tws_pkg::CTRL_DONE];
  // a new event is shown only once software has released the previous one
  assign pop = buf_valid && !done_q;

  tws_line_mon u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .bus_busy(bus_busy),
    .sda_now(sda_now)
  );

  tws_buf2 #(
    .WIDTH(tws_pkg::EV_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!on_q),
    .in_valid(ev_valid_q),
    .in_ready(ev_ready),
    .in_data(ev_data_q),
    .out_valid(buf_valid),
    .out_ready(!done_q),
    .out_data(buf_data)
  );

  // read mux, captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (idx == tws_pkg::IDX_DIVIDER) begin
        prdata_q <= {24'h000000, divider_q};
      end else if (idx == tws_pkg::IDX_STATUS) begin
        // R7 status layout, reserved bit 2 reads zero
        prdata_q <= {24'h000000, code_q, 1'b0, prescale_q};
      end else if (idx == tws_pkg::IDX_OWN) begin
        prdata_q <= {24'h000000, own_addr_q, gce_q};
      end else if (idx == tws_pkg::IDX_DATA) begin
        prdata_q <= {24'h000000, data_q};
      end else if (idx == tws_pkg::IDX_CTRL) begin
        // R9 control layout, bit 1 reads zero
        prdata_q <= {24'h000000, done_q, ack_en_q, begin_q, halt_q, wcol_q, on_q, 1'b0,
                     irq_en_q};
      end else if (idx == tws_pkg::IDX_MASK) begin
        prdata_q <= {24'h000000, mask_q, 1'b0};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_q <= tws_pkg::RST_DIVIDER;
      prescale_q <= tws_pkg::RST_PRESCALE;
      own_addr_q <= tws_pkg::RST_OWN[7:1];
      gce_q <= tws_pkg::RST_OWN[0];
      mask_q <= tws_pkg::RST_MASK;
    end else if (wr_en) begin
      if (idx == tws_pkg::IDX_DIVIDER) begin
        // R10 full byte divider
        divider_q <= pwdata[7:0];
      end else if (idx == tws_pkg::IDX_STATUS) begin
        // R7 only the prescaler bits are writable
        prescale_q <= pwdata[1:0];
      end else if (idx == tws_pkg::IDX_OWN) begin
        // R8 own address and general call enable
        own_addr_q <= pwdata[7:tws_pkg::OWN_ADDR_LSB];
        gce_q <= pwdata[tws_pkg::OWN_GCE];
      end else if (idx == tws_pkg::IDX_MASK) begin
        // R12 seven mask bits above bit 0
        mask_q <= pwdata[7:1];
      end
    end
  end

  // control bits; software owns ack, begin, on, irq; halt clears itself after a STOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_en_q <= 1'b0;
      begin_q <= 1'b0;
      halt_q <= 1'b0;
      on_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else if (wr_en && idx == tws_pkg::IDX_CTRL) begin
      ack_en_q <= pwdata[tws_pkg::CTRL_ACK];
      begin_q <= pwdata[tws_pkg::CTRL_BEGIN];
      halt_q <= pwdata[tws_pkg::CTRL_HALT];
      on_q <= pwdata[tws_pkg::CTRL_ON];
      irq_en_q <= pwdata[tws_pkg::CTRL_IRQ];
    end else if (halt_done) begin
      halt_q <= 1'b0;
    end
  end

  // done flag and the status code it qualifies; set only while done is low, so no clash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      code_q <= tws_pkg::SC_NONE;
    end else if (pop) begin
      done_q <= 1'b1;
      code_q <= buf_data[tws_pkg::EV_W-1:8];
    end else if (release_pulse) begin
      done_q <= 1'b0;
      code_q <= tws_pkg::SC_NONE;
    end
  end

  // data register and write collision flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= tws_pkg::RST_DATA;
      wcol_q <= 1'b0;
    end else if (pop) begin
      // R1 received byte lands here for software to read
      data_q <= buf_data[7:0];
      // a data write in this cycle still met done low, so it collides
      wcol_q <= wcol_q || (wr_en && idx == tws_pkg::IDX_DATA);
    end else if (wr_en && idx == tws_pkg::IDX_DATA) begin
      // R11 byte to send is accepted only while the engine waits on software
      if (done_q) begin
        data_q <= pwdata[7:0];
        wcol_q <= 1'b0;
      end else begin
        wcol_q <= 1'b1;
      end
    end
  end

  // bus engine: slave receiver plus START/STOP generation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tws_pkg::E_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addressed_q <= 1'b0;
      gc_q <= 1'b0;
      ack_q <= 1'b0;
      pend_code_q <= tws_pkg::SC_NONE;
      ev_valid_q <= 1'b0;
      ev_data_q <= '0;
      hold_cnt_q <= 16'h0000;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      halt_done <= 1'b0;
    end else if (!on_q) begin
      state_q <= tws_pkg::E_IDLE;
      addressed_q <= 1'b0;
      ev_valid_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      halt_done <= 1'b0;
    end else begin
      halt_done <= 1'b0;
      if (ev_valid_q && ev_ready) begin
        ev_valid_q <= 1'b0;
      end
      // slave stretch: clock held low while an event waits for buffer space
      if (state_q != tws_pkg::E_MHOLD && state_q != tws_pkg::E_MSTOP) begin
        scl_oe_q <= ev_valid_q && !ev_ready;
      end
      if ((start_seen || stop_seen) && state_q != tws_pkg::E_MSTART &&
          state_q != tws_pkg::E_MHOLD && state_q != tws_pkg::E_MSTOP) begin
        // R2 condition while still addressed is reported
        if (addressed_q && !ev_valid_q) begin
          ev_valid_q <= 1'b1;
          ev_data_q <= {tws_pkg::SC_STOP, 8'hFF};
        end
        addressed_q <= 1'b0;
        sda_oe_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        state_q <= start_seen ? tws_pkg::E_ADDR : tws_pkg::E_IDLE;
      end else begin
        case (state_q)
          tws_pkg::E_IDLE: begin
            // R5 queued START waits for a free bus
            if (begin_q && !bus_busy && !done_q && !ev_valid_q && !buf_valid) begin
              sda_oe_q <= 1'b1;
              hold_cnt_q <= tws_pkg::tws_hold_cycles(divider_q, prescale_q);
              state_q <= tws_pkg::E_MSTART;
            end
          end
          tws_pkg::E_ADDR, tws_pkg::E_DATA: begin
            if (scl_rise && !ev_valid_q) begin
              shift_q <= {shift_q[6:0], sda_now};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == tws_pkg::BITS_PER_BYTE) begin
              bit_cnt_q <= 4'h0;
              if (state_q == tws_pkg::E_ADDR) begin
                // R3 R4 R12 recognition follows ack enable, mask and general call enable
                if (ack_en_q && !shift_q[0] &&
                    tws_pkg::tws_addr_match(shift_q[7:1], own_addr_q, mask_q)) begin
                  sda_oe_q <= 1'b1;
                  gc_q <= 1'b0;
                  pend_code_q <= tws_pkg::SC_OWN_ACK;
                  state_q <= tws_pkg::E_ADDR_ACK;
                end else if (ack_en_q && gce_q && shift_q == {tws_pkg::GC_ADDR, 1'b0}) begin
                  sda_oe_q <= 1'b1;
                  gc_q <= 1'b1;
                  pend_code_q <= tws_pkg::SC_GC_ACK;
                  state_q <= tws_pkg::E_ADDR_ACK;
                end else begin
                  state_q <= tws_pkg::E_IDLE;
                end
              end else begin
                // R1 general-call byte with ack enable low is answered NOT ACK
                ack_q <= ack_en_q;
                sda_oe_q <= ack_en_q;
                if (gc_q) begin
                  pend_code_q <= ack_en_q ? tws_pkg::SC_GC_DATA_ACK : tws_pkg::SC_GC_DATA_NACK;
                end else begin
                  pend_code_q <= ack_en_q ? tws_pkg::SC_DATA_ACK : tws_pkg::SC_DATA_NACK;
                end
                state_q <= tws_pkg::E_DATA_ACK;
              end
            end
          end
          tws_pkg::E_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              addressed_q <= 1'b1;
              ev_valid_q <= 1'b1;
              ev_data_q <= {pend_code_q, shift_q};
              state_q <= tws_pkg::E_DATA;
            end
          end
          tws_pkg::E_DATA_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              ev_valid_q <= 1'b1;
              ev_data_q <= {pend_code_q, shift_q};
              // R1 after NOT ACK the engine drops to not-addressed mode
              addressed_q <= ack_q;
              state_q <= ack_q ? tws_pkg::E_DATA : tws_pkg::E_IDLE;
            end
          end
          tws_pkg::E_MSTART: begin
            if (hold_cnt_q != 16'h0000) begin
              hold_cnt_q <= hold_cnt_q - 16'h0001;
            end else begin
              // R5 START done: hold the clock low and report it
              scl_oe_q <= 1'b1;
              ev_valid_q <= 1'b1;
              ev_data_q <= {tws_pkg::SC_START, data_q};
              state_q <= tws_pkg::E_MHOLD;
            end
          end
          tws_pkg::E_MHOLD: begin
            // the bus stays held until software asks for a STOP
            if (release_pulse && pwdata[tws_pkg::CTRL_HALT]) begin
              scl_oe_q <= 1'b0;
              hold_cnt_q <= tws_pkg::tws_hold_cycles(divider_q, prescale_q);
              state_q <= tws_pkg::E_MSTOP;
            end
          end
          tws_pkg::E_MSTOP: begin
            if (hold_cnt_q != 16'h0000) begin
              hold_cnt_q <= hold_cnt_q - 16'h0001;
            end else begin
              sda_oe_q <= 1'b0;
              halt_done <= 1'b1;
              state_q <= tws_pkg::E_IDLE;
            end
          end
          default: begin
            state_q <= tws_pkg::E_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign job_done = done_q;
  assign interrupt_on = irq_en_q;
endmodule

// ==== shared/tws_pkg.sv ====
// Purpose: constants, types and helpers shared by the two-wire slave block
// Assumes: 125 MHz pclk, register indices are word indices on APB (byte = 4 * index)
// Notes: state codes are kept as five-bit values; the status register shifts them up by 3
//
// What this block does
// R1: general-call data answered NOT ACK reports code 0x98, byte in data register
// R2: STOP or repeated START while addressed reports code 0xA0
// R3: release with ack enable 0 ignores own and general call address
// R4: release with ack enable 1 recognises own address, general call if enabled
// R5: release with begin request sends START once the bus is free
// R6: software masks the prescaler bits before decoding the state code
// R7: status register holds code in bits 7..3, prescaler in bits 1..0
// R8: own address register holds address in bits 7..1, general call enable bit 0
// R9: control register bit layout: done, ack, begin, halt, collision, on, irq
// R10: bit rate divider register is a full eight-bit field
// R11: data register is eight bits, byte to send or byte received
// R12: address mask register set bits exclude own-address bits from compare
// R13: software releases with done written 1 and halt written 0
package tws_pkg;

  // register word indices
  localparam logic [7:0] IDX_DIVIDER = 8'hB8;
  localparam logic [7:0] IDX_STATUS = 8'hB9;
  localparam logic [7:0] IDX_OWN = 8'hBA;
  localparam logic [7:0] IDX_DATA = 8'hBB;
  localparam logic [7:0] IDX_CTRL = 8'hBC;
  localparam logic [7:0] IDX_MASK = 8'hBD;

  // control register bit positions
  localparam int unsigned CTRL_DONE = 7;
  localparam int unsigned CTRL_ACK = 6;
  localparam int unsigned CTRL_BEGIN = 5;
  localparam int unsigned CTRL_HALT = 4;
  localparam int unsigned CTRL_WCOL = 3;
  localparam int unsigned CTRL_ON = 2;
  localparam int unsigned CTRL_IRQ = 0;

  // status and address field layout
  localparam int unsigned STAT_CODE_LSB = 3;
  localparam int unsigned OWN_ADDR_LSB = 1;
  localparam int unsigned OWN_GCE = 0;

  // reset values
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [7:0] RST_OWN = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [6:0] RST_MASK = 7'h00;
  localparam logic [1:0] RST_PRESCALE = 2'h0;

  // five-bit state codes (byte value = code << 3)
  localparam logic [4:0] SC_START = 5'h01;         // 0x08
  localparam logic [4:0] SC_OWN_ACK = 5'h0C;       // 0x60
  localparam logic [4:0] SC_GC_ACK = 5'h0E;        // 0x70
  localparam logic [4:0] SC_DATA_ACK = 5'h10;      // 0x80
  localparam logic [4:0] SC_DATA_NACK = 5'h11;     // 0x88
  localparam logic [4:0] SC_GC_DATA_ACK = 5'h12;   // 0x90
  localparam logic [4:0] SC_GC_DATA_NACK = 5'h13;  // 0x98
  localparam logic [4:0] SC_STOP = 5'h14;          // 0xA0
  localparam logic [4:0] SC_NONE = 5'h1F;          // 0xF8

  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [15:0] START_BASE_CYC = 16'h0010; // fixed part of START hold

  // one buffer entry: state code and byte
  localparam int unsigned EV_W = 13;

  typedef enum {
    E_IDLE, E_ADDR, E_ADDR_ACK, E_DATA, E_DATA_ACK, E_MSTART, E_MHOLD, E_MSTOP
  } tws_state_t;

  // masked compare of a received address against the own address
  function automatic logic tws_addr_match(input logic [6:0] rx, input logic [6:0] own,
                                          input logic [6:0] mask);
    tws_addr_match = ((rx ^ own) & ~mask) == 7'h00;
  endfunction

  // START/STOP hold time in pclk cycles from divider and prescaler
  function automatic logic [15:0] tws_hold_cycles(input logic [7:0] div, input logic [1:0] ps);
    logic [15:0] scaled;
    scaled = {8'h00, div} << {ps, 1'b0};
    tws_hold_cycles = START_BASE_CYC + scaled;
  endfunction

endpackage

// ==== rtl/tws_buf2.sv ====
// Purpose: small valid/ready buffer between the bus engine and the register side
// Assumes: single clock, both sides handshake on the same edge
// Notes: depth defaults to two so one stalled entry never blocks the next
`timescale 1ns/10ps
module tws_buf2 #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refuse a depth the wrapping pointers cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("tws_buf2: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // honest full/empty straight from the fill count
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, written only on an accepted push
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ==== rtl/tws_line_mon.sv ====
// Purpose: watch the clock and data lines for edges, START and STOP
// Assumes: line inputs already synchronous to pclk
// Notes: edge, condition and sda_now outputs are decoded from two sample flops, one cycle behind the pins; bus_busy is a flop one cycle later
`timescale 1ns/10ps
module tws_line_mon (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic bus_busy,
  output logic sda_now
);
  logic scl_q;
  logic sda_q;
  logic scl_p_q;
  logic sda_p_q;
  logic busy_q;

  // two samples of each line; idle lines read high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_p_q;
  assign scl_fall = !scl_q && scl_p_q;
  // data moving while the clock stays high marks a condition
  assign start_seen = scl_q && scl_p_q && !sda_q && sda_p_q;
  assign stop_seen = scl_q && scl_p_q && sda_q && !sda_p_q;
  assign sda_now = sda_q;
  assign bus_busy = busy_q;

  // bus is owned from a START until the next STOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (start_seen) begin
      busy_q <= 1'b1;
    end else if (stop_seen) begin
      busy_q <= 1'b0;
    end
  end
endmodule

// ==== test/tws_props.sv ====
// Purpose: port checks for the two-wire slave block
// Assumes: register index is paddr[9:2], zero wait states
// Notes: read data is caught in setup, so flags are taken one cycle back
`timescale 1ns/10ps
module tws_props #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic job_done,
  input wire logic interrupt_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access decode shared by the checks
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire [7:0] idx = paddr[9:2];
  wire rel = acc && pwrite && idx == 8'hBC && pwdata[7];
  sequence s_rd(i);
    rd && idx == i;
  endsequence
  // sda pulled while scl is high can only be our own start
  sequence s_begin;
    $rose(sda_oe) && scl_in;
  endsequence
  stat_idle_a: assert property (s_rd(8'hB9) ##0 !$past(job_done)
    |-> prdata[7:2] == 6'h3E) else $error("status not idle code");
  stat_evt_a: assert property (s_rd(8'hB9) ##0 $past(job_done)
    |-> prdata[7:3] != 5'h1F) else $error("event without code");
  ctrl_map_a: assert property (s_rd(8'hBC)
    |-> prdata[7] == $past(job_done) && prdata[0] == $past(interrupt_on))
    else $error("control bits misplaced");
  irq_wr_a: assert property (acc && pwrite && idx == 8'hBC
    |=> interrupt_on == $past(pwdata[0])) else $error("irq bit not written");
  err_map_a: assert property (acc |-> pslverr == (idx < 8'hB8 || idx > 8'hBD))
    else $error("slave error map");
  hi_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  start_hold_a: assert property (s_begin |-> (sda_oe && !scl_oe) [*8])
    else $error("start hold short");
  done_rel_a: assert property (rel && job_done |=> !job_done)
    else $error("done not cleared");
  done_keep_a: assert property ($fell(job_done) |-> $past(rel))
    else $error("done cleared alone");
endmodule
bind tws_top tws_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .scl_in,
  .scl_oe, .sda_oe, .job_done, .interrupt_on
);

// ==== test/tws_bus_master.sv ====
// Purpose: another master on the two-wire bus
// Assumes: lines are wired-and with pull-ups outside
// Notes: waits on a stretched clock, so a stuck slave hangs until the bench timeout
`timescale 1ns/10ps
module tws_bus_master #(
  parameter int T = 8
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // release the clock and honour stretching
  task automatic up;
    scl_low <= 1'b0;
    tk(1);
    while (scl !== 1'b1) tk(1);
    tk(T);
  endtask
  task automatic start;
    sda_low <= 1'b1;
    tk(T);
    scl_low <= 1'b1;
    tk(T);
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    tk(T);
    up();
    sda_low <= 1'b0;
    tk(T);
  endtask
  // msb first, then the answer bit read at the end of its high time
  task automatic wbyte(input logic [7:0] b, output logic nack);
    for (int k = 7; k >= 0; k--) begin
      sda_low <= !b[k];
      tk(T);
      up();
      scl_low <= 1'b1;
    end
    sda_low <= 1'b0;
    tk(T);
    up();
    nack = sda;
    scl_low <= 1'b1;
    tk(T);
  endtask
endmodule

// ==== test/test_two_wire_slave_end_handling.sv ====
// Purpose: self-checking bench for the two-wire slave block
// Assumes: one outside master, registers over APB
// Notes: slave end states are walked with general call and own address
`timescale 1ns/10ps
module test_two_wire_slave_end_handling;
  logic pclk, presetn, psel, penable, pwrite, perr, nack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, scl_oe, sda_oe, job_done, interrupt_on, m_scl, m_sda;
  logic scl_out, sda_out;
  logic [7:0] rdat;
  int n_errors = 0, checked = 0, cyc = 0;
  // open-drain lines with pull-ups
  wire scl = !m_scl && (scl_oe ? scl_out : 1'b1);
  wire sda = !m_sda && (sda_oe ? sda_out : 1'b1);
  tws_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
    .sda_oe, .job_done, .interrupt_on);
  tws_bus_master u_mst (.pclk, .scl, .sda, .scl_low(m_scl), .sda_low(m_sda));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // hang guard, far above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), e, rdat);
  endtask
  // wait for an event, check code and, unless it is a START, byte, then answer it
  task automatic ev(input logic [7:0] code, input logic [7:0] d, input logic [7:0] r);
    while (job_done !== 1'b1) @(posedge pclk);
    apb(1'b0, 8'hB9, 8'h00);
    chk("status", code, rdat & 8'hF8);
    if (code != 8'h08) rc(8'hBB, d);
    apb(1'b1, 8'hBC, r);
  endtask
  task automatic t_regs;
    logic [7:0] rv [6];
    rv = '{8'h00, 8'hF8, 8'h00, 8'hFF, 8'h00, 8'h00};
    for (int k = 0; k < 6; k++) rc(8'hB8 + 8'(k), rv[k]);
    apb(1'b1, 8'hBE, 8'h55);
    chk("pslverr", 8'h01, {7'h00, perr});
    rc(8'hBE, 8'h00);
    apb(1'b1, 8'hB9, 8'hFF);
    rc(8'hB9, 8'hFB);
    apb(1'b1, 8'hB8, 8'h02);
    rc(8'hB8, 8'h02);
    apb(1'b1, 8'hBA, 8'h55);
    rc(8'hBA, 8'h55);
    apb(1'b1, 8'hBD, 8'h04);
    rc(8'hBD, 8'h04);
    apb(1'b1, 8'hBB, 8'h12);
    rc(8'hBB, 8'hFF);
    rc(8'hBC, 8'h08);
  endtask
  // general call data refused, then ack enable off ignores own address
  task automatic t_gcall;
    apb(1'b1, 8'hBC, 8'h45);
    u_mst.start();
    u_mst.wbyte(8'h00, nack);
    chk("gc ack", 8'h00, {7'h00, nack});
    ev(8'h70, 8'h00, 8'h84);
    u_mst.wbyte(8'h5A, nack);
    chk("gc nack", 8'h01, {7'h00, nack});
    ev(8'h98, 8'h5A, 8'h84);
    u_mst.stop();
    u_mst.start();
    u_mst.wbyte(8'h54, nack);
    chk("own off", 8'h01, {7'h00, nack});
    u_mst.stop();
  endtask
  // masked own address, stop while addressed, queued start
  task automatic t_own;
    apb(1'b1, 8'hBC, 8'h44);
    u_mst.start();
    u_mst.wbyte(8'h50, nack);
    chk("own ack", 8'h00, {7'h00, nack});
    ev(8'h60, 8'h50, 8'hC4);
    u_mst.wbyte(8'hA5, nack);
    chk("data ack", 8'h00, {7'h00, nack});
    ev(8'h80, 8'hA5, 8'hC4);
    u_mst.stop();
    ev(8'hA0, 8'hFF, 8'hE4);
    ev(8'h08, 8'h00, 8'hD4);
    while (sda_oe !== 1'b0) @(posedge pclk);
    chk("scl free", 8'h00, {7'h00, scl_oe});
  endtask
  // general call refused once its enable is off
  task automatic t_gc_off;
    apb(1'b1, 8'hBA, 8'h54);
    u_mst.start();
    u_mst.wbyte(8'h00, nack);
    chk("gc off", 8'h01, {7'h00, nack});
    u_mst.stop();
    u_mst.start();
    u_mst.wbyte(8'h54, nack);
    ev(8'h60, 8'h54, 8'hC4);
    u_mst.up();
    u_mst.start();
    ev(8'hA0, 8'hFF, 8'hC4);
    u_mst.stop();
    rc(8'hB9, 8'hFB);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_gcall();
    t_own();
    t_gc_off();
    test_done();
  end
endmodule
